//--- ctsr_defines.svh
// offsets, field positions, reset values and codes for the charger thermal/status registers
`ifndef CTSR_DEFINES_SVH
`define CTSR_DEFINES_SVH

`define CTSR_OFS_THERM_CTRL    8'h18
`define CTSR_OFS_LIMIT_RB      8'h19
`define CTSR_OFS_STATUS_FIRST  8'h1B
`define CTSR_THERM_CTRL_RESET  8'h54
`define CTSR_COOL_DEFAULT      2'h1
`define CTSR_WARM_DEFAULT      2'h1
`define CTSR_HOT_DEFAULT       2'h1
`define CTSR_COLD_DEFAULT      1'h0
`define CTSR_BYPASS_DEFAULT    1'h0
`define CTSR_HOT_DISABLE       2'h3
`define CTSR_COOL_MSB          7
`define CTSR_COOL_LSB          6
`define CTSR_WARM_MSB          5
`define CTSR_WARM_LSB          4
`define CTSR_HOT_MSB           3
`define CTSR_HOT_LSB           2
`define CTSR_COLD_BIT          1
`define CTSR_BYPASS_BIT        0
`define CTSR_ST_IREG_BIT       7
`define CTSR_ST_VREG_BIT       6
`define CTSR_ST_WDOG_BIT       5
`define CTSR_ST_RSVD_BIT       4
`define CTSR_ST_PGOOD_BIT      3
`define CTSR_ST_IN2_BIT        2
`define CTSR_ST_IN1_BIT        1
`define CTSR_ST_BUS_BIT        0
`define CTSR_LIMIT_WIDTH       9
`define CTSR_LIMIT_STEP_MA     10
`define CTSR_LIMIT_MIN_CODE    9'h00A
`define CTSR_LIMIT_MAX_CODE    9'h14A
// comparator levels in tenths of a percent of the regulator rail
`define CTSR_COOL_LVL0         10'h2C7
`define CTSR_COOL_LVL1         10'h2AC
`define CTSR_COOL_LVL2         10'h28F
`define CTSR_COOL_LVL3         10'h270
`define CTSR_WARM_LVL0         10'h1E4
`define CTSR_WARM_LVL1         10'h1C0
`define CTSR_WARM_LVL2         10'h19C
`define CTSR_WARM_LVL3         10'h179
// otg hot limit in degrees C
`define CTSR_HOT_C0            7'h37
`define CTSR_HOT_C1            7'h3C
`define CTSR_HOT_C2            7'h41

`endif

//--- ctsr_pkg.sv
// types shared by the charger thermal/status register bank
package ctsr_pkg;

  // thermistor control register fields, msb first as laid out in the byte
  typedef struct packed {
    logic [1:0] coolSel;
    logic [1:0] warmSel;
    logic [1:0] hotSel;
    logic       coldSel;
    logic       bypass;
  } ctsr_therm_ctrl_t;

  // live conditions from the analog and regulation side
  typedef struct packed {
    logic inputCurrentReg;
    logic inputVoltageReg;
    logic watchdogExpired;
    logic powerGood;
    logic secondInputPresent;
    logic firstInputPresent;
    logic busInputPresent;
  } ctsr_live_t;

  // register access request from the serial interface engine
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } ctsr_req_t;

  // translated thermal settings for the analog side
  typedef struct packed {
    logic [9:0] coolLevel;
    logic [9:0] warmLevel;
    logic [6:0] hotLimitC;
    logic       hotCheckEn;
    logic       coldSel;
    logic       bypass;
  } ctsr_therm_cfg_t;

endpackage : ctsr_pkg

//--- ctsr_sync.sv
// three-flop synchroniser with agreement filter for WIDTH independent asynchronous levels
`timescale 1ns/100ps
`include "ctsr_defines.svh"

module ctsr_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // asynchronous level in, filtered level out
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;

  // first flop feeds only the second, so no logic sees a metastable value
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
    end
  end

  // a bit changes only once the second and third stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      syncOut <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2_q[i] == stage3_q[i]) begin
          syncOut[i] <= stage3_q[i];
        end
      end
    end
  end

endmodule : ctsr_sync

//--- charger_thermal_status_regs.sv
// register bank slice: thermistor control, obtained input limit, first status
`timescale 1ns/100ps
`include "ctsr_defines.svh"

// Behaviour
// - cool select picks rising comparator level 71.1/68.4/65.5/62.4 percent, default 1
// - warm select picks falling comparator level 48.4/44.8/41.2/37.7 percent, default 1
// - otg hot select: 55, 60 default, 65 degrees; code 3 disables check
// - bypass forces thermistor good, allows charge and otg, status bits 0000
// - thermistor control at 18h resets 54h; watchdog or defaults command restores
// - 9-bit obtained limit, 10mA per step, 100-3300mA, clamped low
// - readback at 19h is 16 bits, resets zero, bits 15-9 read zero
// - status bit 7 shows input or otg current regulation active
// - status bit 6 shows input or otg voltage regulation active
// - status bit 5 shows host watchdog expired
// - status bit 3 shows input power good
// - status bits 2 and 1 show second and first input present
// - status register at 1Bh resets zero, bit 4 reads zero
// - status bit 0 shows bus input present
module charger_thermal_status_regs #(
  parameter int LIMIT_WIDTH = `CTSR_LIMIT_WIDTH
) (
  // clock and reset
  input  wire logic                       clk,
  input  wire logic                       rst,
  // register access from the serial interface engine, same clock
  input  wire ctsr_pkg::ctsr_req_t        req,
  output logic      [15:0]                rdData,
  output logic                            rdValid,
  output logic                            addrHit,
  // register-wide restore events, same clock
  input  wire logic                       watchdogExpiry,
  input  wire logic                       registerDefaultsCmd,
  // obtained limit from optimiser or limit pin, same clock
  input  wire logic [LIMIT_WIDTH-1:0]     obtainedLimitIn,
  // live analog conditions, asynchronous
  input  wire ctsr_pkg::ctsr_live_t       liveIn,
  // raw thermistor comparator flags, asynchronous, four bits
  input  wire logic [3:0]                 thermStatusIn,
  // configuration and derived thermal view
  output ctsr_pkg::ctsr_therm_ctrl_t      thermCtrl,
  output ctsr_pkg::ctsr_therm_cfg_t       thermCfg,
  output logic      [3:0]                 thermStatus,
  output logic                            thermGood
);

  // register map of this slice:
  //   18h thermistor control, read/write, restored to 54h
  //   19h obtained input limit, read only, 16 bits wide
  //   1Bh first charger status, read only, live flags
  // only the control byte holds host state; the other two mirror hardware

  ctsr_pkg::ctsr_therm_ctrl_t therm_q;
  ctsr_pkg::ctsr_live_t       liveSync;
  logic [3:0]                 thermSync;
  logic [LIMIT_WIDTH-1:0]     limit_q;
  logic [7:0]                 status_q;
  logic [3:0]                 thermStat_q;
  logic                       restore;
  // per-register address hits
  logic                       hitCtrl;
  logic                       hitLimit;
  logic                       hitStatus;

  // level translation tables, shared by the config output
  function automatic logic [9:0] coolLevel(input logic [1:0] sel);
    case (sel)
      2'h0:    coolLevel = `CTSR_COOL_LVL0;
      2'h1:    coolLevel = `CTSR_COOL_LVL1;
      2'h2:    coolLevel = `CTSR_COOL_LVL2;
      default: coolLevel = `CTSR_COOL_LVL3;
    endcase
  endfunction : coolLevel

  // warm comparator falling levels, same units as the cool ones
  function automatic logic [9:0] warmLevel(input logic [1:0] sel);
    case (sel)
      2'h0:    warmLevel = `CTSR_WARM_LVL0;
      2'h1:    warmLevel = `CTSR_WARM_LVL1;
      2'h2:    warmLevel = `CTSR_WARM_LVL2;
      default: warmLevel = `CTSR_WARM_LVL3;
    endcase
  endfunction : warmLevel

  // otg hot limit in whole degrees
  function automatic logic [6:0] hotLimit(input logic [1:0] sel);
    case (sel)
      2'h0:    hotLimit = `CTSR_HOT_C0;
      2'h1:    hotLimit = `CTSR_HOT_C1;
      2'h2:    hotLimit = `CTSR_HOT_C2;
      default: hotLimit = 7'h00;  // check disabled, value unused
    endcase
  endfunction : hotLimit

  // analog levels arrive asynchronously, so they are filtered before use
  // pin to status read costs three sync stages, one agreement cycle and one
  // status register; a glitch shorter than two clocks may never be seen,
  // which suits regulation and presence levels that move slowly
  ctsr_sync #(
    .WIDTH ($bits(ctsr_pkg::ctsr_live_t) + 4)
  ) u_sync (
    .clk     (clk),
    .rst     (rst),
    .asyncIn ({liveIn, thermStatusIn}),
    .syncOut ({liveSync, thermSync})
  );

  // either restore event returns every control field to its default
  assign restore = watchdogExpiry || registerDefaultsCmd;

  // address decode; one comparator per register, shared by write, read and hit flag
  assign hitCtrl   = (req.addr == `CTSR_OFS_THERM_CTRL);
  assign hitLimit  = (req.addr == `CTSR_OFS_LIMIT_RB);
  assign hitStatus = (req.addr == `CTSR_OFS_STATUS_FIRST);

  // reset value and restore
  // restore wins over a write in the same cycle so a dead host cannot keep stale settings
  always_ff @(posedge clk) begin
    if (rst || restore) begin
      therm_q <= `CTSR_THERM_CTRL_RESET;
    end else if (req.wrEn && hitCtrl) begin
      therm_q <= req.wrData;
    end
  end

  // clamped low at the bottom of the range, and held at the top
  // the top clamp keeps a stray code from reading above the 3300mA ceiling;
  // the register still shows zero until the first clock after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      limit_q <= '0;
    end else if (obtainedLimitIn < LIMIT_WIDTH'(`CTSR_LIMIT_MIN_CODE)) begin
      limit_q <= LIMIT_WIDTH'(`CTSR_LIMIT_MIN_CODE);
    end else if (obtainedLimitIn > LIMIT_WIDTH'(`CTSR_LIMIT_MAX_CODE)) begin
      limit_q <= LIMIT_WIDTH'(`CTSR_LIMIT_MAX_CODE);
    end else begin
      limit_q <= obtainedLimitIn;
    end
  end

  // live status sampled every cycle; reads see at most one cycle of age
  // nothing is latched: each flag clears by itself when its filtered level drops,
  // so a host that polls slowly can miss a short regulation episode
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= 8'h00;
    end else begin
      status_q[`CTSR_ST_IREG_BIT]  <= liveSync.inputCurrentReg;
      status_q[`CTSR_ST_VREG_BIT]  <= liveSync.inputVoltageReg;
      status_q[`CTSR_ST_WDOG_BIT]  <= liveSync.watchdogExpired;
      status_q[`CTSR_ST_RSVD_BIT]  <= 1'b0;
      status_q[`CTSR_ST_PGOOD_BIT] <= liveSync.powerGood;
      status_q[`CTSR_ST_IN2_BIT]   <= liveSync.secondInputPresent;
      status_q[`CTSR_ST_IN1_BIT]   <= liveSync.firstInputPresent;
      status_q[`CTSR_ST_BUS_BIT]   <= liveSync.busInputPresent;
    end
  end

  // bypass masks the four thermistor status bits
  // raw bits stay synchronised under bypass, so clearing it shows them a cycle later
  always_ff @(posedge clk) begin
    if (rst) begin
      thermStat_q <= 4'h0;
    end else begin
      thermStat_q <= therm_q.bypass ? 4'h0 : thermSync;
    end
  end

  // read path; every read answers with rdValid, unmapped addresses with zero
  // a read and a write in one cycle return the old control byte
  // rdData holds between reads so a slow serial engine can fetch it late
  always_ff @(posedge clk) begin
    if (rst) begin
      rdData  <= 16'h0000;
      rdValid <= 1'b0;
    end else begin
      rdValid <= req.rdEn;
      if (!req.rdEn) begin
        rdData <= rdData;
      end else if (hitCtrl) begin
        rdData <= {8'h00, therm_q};
      end else if (hitLimit) begin
        rdData <= {(16 - LIMIT_WIDTH)'(0), limit_q};
      end else if (hitStatus) begin
        rdData <= {8'h00, status_q};
      end else begin
        rdData <= 16'h0000;  // unmapped reads return zero
      end
    end
  end

  // writes to readback and status touch nothing, only flagged as hit
  assign addrHit = hitCtrl || hitLimit || hitStatus;

  // raw control byte and masked status for the analog side
  assign thermCtrl   = therm_q;
  assign thermStatus = thermStat_q;
  assign thermGood   = therm_q.bypass || (thermSync == 4'h0);

  // translated view follows the control byte combinationally, with no extra delay
  // cool, warm and hot levels
  assign thermCfg.coolLevel  = coolLevel(therm_q.coolSel);
  assign thermCfg.warmLevel  = warmLevel(therm_q.warmSel);
  assign thermCfg.hotLimitC  = hotLimit(therm_q.hotSel);
  assign thermCfg.hotCheckEn = (therm_q.hotSel != `CTSR_HOT_DISABLE) && !therm_q.bypass;
  // cold select has no decode here; the analog side uses the bit as is
  assign thermCfg.coldSel    = therm_q.coldSel;
  assign thermCfg.bypass     = therm_q.bypass;

endmodule : charger_thermal_status_regs

//--- ctsr_properties.sv
// concurrent checks on the thermal/status register bank ports
`timescale 1ns/100ps

module ctsr_properties (
  // clock and reset
  input wire logic                       clk,
  input wire logic                       rst,
  // register bus
  input wire ctsr_pkg::ctsr_req_t        req,
  input wire logic [15:0]                rdData,
  input wire logic                       rdValid,
  input wire logic                       addrHit,
  // restore events
  input wire logic                       watchdogExpiry,
  input wire logic                       registerDefaultsCmd,
  // thermal view
  input wire ctsr_pkg::ctsr_therm_ctrl_t thermCtrl,
  input wire ctsr_pkg::ctsr_therm_cfg_t  thermCfg,
  input wire logic [3:0]                 thermStatus,
  input wire logic                       thermGood
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic restore;
  logic wr18;
  // restore events beat a write in the same cycle
  assign restore = watchdogExpiry | registerDefaultsCmd;
  assign wr18    = req.wrEn && req.addr == 8'h18;

  wr_ctrl_a: assert property (wr18 && !restore |=> thermCtrl == $past(req.wrData))
    else $error("control write lost");
  restore_ctrl_a: assert property (restore |=> thermCtrl == 8'h54)
    else $error("control not restored");
  ctrl_hold_a: assert property (!wr18 && !restore |=> $stable(thermCtrl))
    else $error("control changed without cause");
  rd_ctrl_a: assert property (req.rdEn && req.addr == 8'h18 |=>
    rdValid && rdData == {8'h00, $past(thermCtrl)})
    else $error("control readback wrong");
  rd_limit_a: assert property (req.rdEn && req.addr == 8'h19 |=>
    rdValid && rdData[15:9] == 7'h00)
    else $error("limit reserved bits set");
  limit_span_a: assert property (req.rdEn && req.addr == 8'h19 && !$past(rst) |=>
    rdData[8:0] >= 9'h00A && rdData[8:0] <= 9'h14A)
    else $error("limit outside clamped span");
  rd_status_a: assert property (req.rdEn && req.addr == 8'h1B |=>
    rdValid && rdData[15:8] == 8'h00 && !rdData[4])
    else $error("status reserved bit set");
  bypass_quiet_a: assert property (thermCtrl.bypass [*2] |->
    thermStatus == 4'h0 && thermGood)
    else $error("bypass did not quiet status");
  hot_off_a: assert property (thermCtrl.hotSel == 2'h3 || thermCtrl.bypass |->
    !thermCfg.hotCheckEn)
    else $error("hot check still enabled");
  addr_hit_a: assert property (addrHit ==
    (req.addr == 8'h18 || req.addr == 8'h19 || req.addr == 8'h1B))
    else $error("address hit wrong");
  cool_lvl_a: assert property (thermCtrl.coolSel == 2'h1 |-> thermCfg.coolLevel == 10'h2AC)
    else $error("cool level wrong");
  warm_lvl_a: assert property (thermCtrl.warmSel == 2'h3 |-> thermCfg.warmLevel == 10'h179)
    else $error("warm level wrong");
endmodule : ctsr_properties

bind charger_thermal_status_regs ctsr_properties chk_u (.clk(clk), .rst(rst), .req(req),
  .rdData(rdData), .rdValid(rdValid), .addrHit(addrHit), .watchdogExpiry(watchdogExpiry),
  .registerDefaultsCmd(registerDefaultsCmd), .thermCtrl(thermCtrl), .thermCfg(thermCfg),
  .thermStatus(thermStatus), .thermGood(thermGood));

//--- ctsr_host_model.sv
// host model issuing register reads and writes
`timescale 1ns/100ps

module ctsr_host_model (
  // clock
  input wire logic            clk,
  // request to the register bank
  output ctsr_pkg::ctsr_req_t req
);
  // idle at time zero
  initial req = '0;
  // one-cycle strobe; fields then flip so a stale address never matches
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wrEn: wr, rdEn: !wr, addr: a, wrData: d};
    @(posedge clk);
    req <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wrData: ~d};
  endtask : xfer
endmodule : ctsr_host_model

//--- tb_top.sv
// self-checking bench for the thermal/status register bank
`timescale 1ns/100ps

module tb_top;
  logic                       clk;
  logic                       rst;
  ctsr_pkg::ctsr_req_t        req;
  logic [15:0]                rdData;
  logic                       rdValid;
  logic                       wdExp;
  logic                       defCmd;
  logic [8:0]                 limitIn;
  ctsr_pkg::ctsr_live_t       live;
  logic [3:0]                 tsIn;
  ctsr_pkg::ctsr_therm_ctrl_t thermCtrl;
  ctsr_pkg::ctsr_therm_cfg_t  thermCfg;
  logic [3:0]                 thermStatus;
  logic                       thermGood;
  int                         miscompares;
  int                         nTests;

  ctsr_host_model host_u (.clk(clk), .req(req));
  charger_thermal_status_regs dut_u (.clk(clk), .rst(rst), .req(req), .rdData(rdData),
    .rdValid(rdValid), .addrHit(), .watchdogExpiry(wdExp), .registerDefaultsCmd(defCmd),
    .obtainedLimitIn(limitIn), .liveIn(live), .thermStatusIn(tsIn), .thermCtrl(thermCtrl),
    .thermCfg(thermCfg), .thermStatus(thermStatus), .thermGood(thermGood));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic ok, input string what);
    nTests++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk

  // read waits out the one-cycle answer, then compares the whole word
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    host_u.xfer(1'b0, a, 8'h00);
    #1;
    chk(rdValid === 1'b1 && rdData === e, $sformatf("read %h got %h", a, rdData));
  endtask : rd

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  // every select code drives the decoded levels
  task automatic t_codes();
    logic [9:0] coolE[4] = '{10'h2C7, 10'h2AC, 10'h28F, 10'h270};
    logic [9:0] warmE[4] = '{10'h1E4, 10'h1C0, 10'h19C, 10'h179};
    logic [6:0] hotE[3]  = '{7'h37, 7'h3C, 7'h41};
    for (int i = 0; i < 4; i++) begin
      host_u.xfer(1'b1, 8'h18, {i[1:0], i[1:0], i[1:0], 2'b00});
      #1;
      chk(thermCfg.coolLevel === coolE[i], "cool level");
      chk(thermCfg.warmLevel === warmE[i], "warm level");
      chk(i == 3 ? thermCfg.hotCheckEn === 1'b0 : thermCfg.hotLimitC === hotE[i], "hot");
    end
  endtask : t_codes

  // bypass hides raw flags and the hot check, clearing it shows the flags again
  task automatic t_bypass();
    @(posedge clk);
    tsIn <= 4'hA;
    host_u.xfer(1'b1, 8'h18, 8'h57);
    repeat (6) @(posedge clk);
    #1;
    chk(thermStatus === 4'h0 && thermGood === 1'b1, "bypass status");
    chk(thermCfg.hotCheckEn === 1'b0 && thermCfg.bypass === 1'b1, "bypass view");
    chk(thermCfg.coldSel === 1'b1 && thermCtrl === 8'h57, "control byte");
    rd(8'h18, 16'h0057);
    host_u.xfer(1'b1, 8'h18, 8'h54);
    repeat (6) @(posedge clk);
    #1;
    chk(thermStatus === 4'hA && thermGood === 1'b0, "raw status");
  endtask : t_bypass

  // both restore events bring the control byte back to its default
  task automatic t_restore();
    for (int j = 1; j < 3; j++) begin
      host_u.xfer(1'b1, 8'h18, 8'hA9);
      @(posedge clk);
      {defCmd, wdExp} <= j[1:0];
      @(posedge clk);
      {defCmd, wdExp} <= 2'b00;
      rd(8'h18, 16'h0054);
    end
  endtask : t_restore

  // limit clamps at both ends; host writes to it are dropped
  task automatic t_limit();
    logic [8:0] vin[4] = '{9'h009, 9'h00A, 9'h14A, 9'h190};
    logic [8:0] vex[4] = '{9'h00A, 9'h00A, 9'h14A, 9'h14A};
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      limitIn <= vin[i];
      @(posedge clk);
      rd(8'h19, {7'h00, vex[i]});
    end
    host_u.xfer(1'b1, 8'h19, 8'hFF);
    rd(8'h19, 16'h014A);
    rd(8'h18, 16'h0054);
  endtask : t_limit

  // live flags land in their bit positions, bit 4 stays clear
  task automatic t_status();
    logic [6:0] pin[2] = '{7'h7F, 7'h2A};
    logic [7:0] pex[2] = '{8'hEF, 8'h4A};
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      live <= pin[i];
      repeat (6) @(posedge clk);
      rd(8'h1B, {8'h00, pex[i]});
    end
    host_u.xfer(1'b1, 8'h1B, 8'hFF);
    rd(8'h1B, 16'h004A);
    rd(8'h18, 16'h0054);
  endtask : t_status

  // main sequence
  initial begin
    rst = 1'b1;
    wdExp = 1'b0;
    defCmd = 1'b0;
    limitIn = 9'h000;
    live = '0;
    tsIn = 4'h0;
    miscompares = 0;
    nTests = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(8'h18, 16'h0054);
    rd(8'h19, 16'h000A);
    rd(8'h1B, 16'h0000);
    rd(8'h1A, 16'h0000);
    t_codes();
    t_bypass();
    t_restore();
    t_limit();
    t_status();
    give_verdict();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
